// ### dts_timer.sv
// Delay-to-stop timer block
// Overview of operation
// - Trigger fall starts a timing operation
// - Trigger rise clears accumulator, stops counting
// - Accumulator counts up from zero to limit
// - Time unit is 1, 10, 100, 1000, 10000 ms
// - Count limit accepts 1 through 32767
// - At limit counting stops, output goes off
// - Plain output 0 at limit, else 1
// - Invert option makes output 1 at limit
// - Early trigger rise ends at zero, no off
// - Limit held while trigger stays low
// - Enable by input or always-on/off constant
// - Disabled: timing continues, output frozen
// - Re-enabled output shows current state at once
// - Timer reset is active low, inhibits timer
// - Reset low forces accumulator zero, output on
// - After reset, new trigger fall restarts timing
// - Power-up leaves timer holding the limit
// - Fault freezes output; clearing loads the limit
`timescale 1ns/1ps
`include "dts_consts.svh"
module dts_timer #(
  parameter int CYCLES_PER_MS = `DTS_CYCLES_PER_MS
) (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic TRIGGER_IN,
  input wire logic ENABLE_IN,
  input wire logic TIMER_RST_N_IN,
  input wire logic FAULT_IN,
  input wire dts_pkg::dts_en_mode_t ENABLE_MODE_IN,
  input wire dts_pkg::dts_unit_t UNIT_SEL_IN,
  input wire logic [`DTS_LIMIT_W-1:0] COUNT_LIMIT_IN,
  input wire logic INVERT_IN,
  output logic OUTPUT_OUT,
  output logic [`DTS_LIMIT_W-1:0] ACCUM_OUT,
  output logic AT_LIMIT_OUT,
  output logic COUNTING_OUT
);
  import dts_pkg::*;

  logic [`DTS_SYNC_W-1:0] sync1;
  logic [`DTS_SYNC_W-1:0] sync2;
  logic trig_prev;
  logic fault_prev;
  logic trig_s;
  logic en_s;
  logic rst_n_s;
  logic fault_s;
  logic trig_fall;
  logic trig_rise;
  logic fault_fall;
  logic enabled;
  logic start;
  logic tick;
  logic quiet;
  logic out_q;
  logic at_limit;
  logic [`DTS_UNIT_MS_W-1:0] ms_per_unit;
  logic [`DTS_LIMIT_W-1:0] eff_limit;
  logic [`DTS_LIMIT_W-1:0] accum;
  logic [`DTS_LIMIT_W-1:0] accum_inc;
  logic [`DTS_LIMIT_W-1:0] next_accum;
  dts_state_t state;
  dts_state_t next_state;

  // Two-stage synchronisers for the pin inputs
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      sync1 <= `DTS_SYNC_IDLE;
      sync2 <= `DTS_SYNC_IDLE;
    end else begin
      sync1 <= {FAULT_IN, TIMER_RST_N_IN, ENABLE_IN, TRIGGER_IN};
      sync2 <= sync1;
    end
  end

  assign trig_s = sync2[`DTS_LANE_TRIG];
  assign en_s = sync2[`DTS_LANE_EN];
  assign rst_n_s = sync2[`DTS_LANE_RSTN];
  assign fault_s = sync2[`DTS_LANE_FAULT];

  // Previous-cycle copies for edge detection
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      trig_prev <= 1'b0;
      fault_prev <= 1'b0;
    end else begin
      trig_prev <= trig_s;
      fault_prev <= fault_s;
    end
  end

  assign trig_fall = trig_prev && !trig_s;
  assign trig_rise = !trig_prev && trig_s;
  assign fault_fall = fault_prev && !fault_s;

  // Accepted start of a timing operation
  assign start = trig_fall && rst_n_s && !fault_s && !fault_fall;
  assign quiet = rst_n_s && !fault_s && !fault_fall && !trig_rise
    && !trig_fall;

  // Time-unit decode
  assign ms_per_unit =
    (UNIT_SEL_IN == DTS_UNIT_10MS) ? `DTS_MS_10 :
    (UNIT_SEL_IN == DTS_UNIT_100MS) ? `DTS_MS_100 :
    (UNIT_SEL_IN == DTS_UNIT_1000MS) ? `DTS_MS_1000 :
    (UNIT_SEL_IN == DTS_UNIT_10000MS) ? `DTS_MS_10000 :
    `DTS_MS_1;

  // Limit of zero is raised to the least legal value
  assign eff_limit = (COUNT_LIMIT_IN < `DTS_LIMIT_MIN) ?
    `DTS_LIMIT_MIN : COUNT_LIMIT_IN;

  // Enable source selection
  assign enabled =
    (ENABLE_MODE_IN == DTS_EN_ALWAYS) ||
    ((ENABLE_MODE_IN == DTS_EN_FOLLOW) && en_s);

  assign accum_inc = accum + `DTS_ACC_ONE;
  assign at_limit = (state == DTS_HOLD);

  dts_prescaler #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
  ) u_prescaler (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .restart_in(start),
    .run_in(state == DTS_COUNT),
    .ms_per_unit_in(ms_per_unit),
    .tick_out(tick)
  );

  // Timer state machine
  always_comb begin
    next_state = state;
    next_accum = accum;
    if (fault_s) begin
      next_state = state;
      next_accum = accum;
    end else if (fault_fall) begin
      next_state = DTS_HOLD;
      next_accum = eff_limit;
    end else if (!rst_n_s) begin
      next_state = DTS_IDLE;
      next_accum = `DTS_ACC_ZERO;
    end else if (trig_rise) begin
      next_state = DTS_IDLE;
      next_accum = `DTS_ACC_ZERO;
    end else if (trig_fall) begin
      next_state = DTS_COUNT;
      next_accum = `DTS_ACC_ZERO;
    end else begin
      unique case (state)
        DTS_IDLE: begin
          next_state = DTS_IDLE;
        end
        DTS_COUNT: begin
          if (tick) begin
            next_accum = accum_inc;
            if (accum_inc >= eff_limit) begin
              next_state = DTS_HOLD;
            end
          end
        end
        DTS_HOLD: begin
          next_state = DTS_HOLD;
        end
        default: begin
          next_state = DTS_HOLD;
          next_accum = eff_limit;
        end
      endcase
    end
  end

  // Power-up leaves the timer at its limit
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      state <= DTS_HOLD;
      accum <= eff_limit;
    end else begin
      state <= next_state;
      accum <= next_accum;
    end
  end

  // Output register, frozen while disabled or in fault
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      out_q <= INVERT_IN;
    end else if (enabled && !fault_s) begin
      out_q <= !at_limit ^ INVERT_IN;
    end
  end

  assign OUTPUT_OUT = out_q;
  assign ACCUM_OUT = accum;
  assign AT_LIMIT_OUT = at_limit;
  assign COUNTING_OUT = (state == DTS_COUNT);

  // Checks
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);

  sequence s_fall_taken;
    trig_fall && rst_n_s && !fault_s && !fault_fall;
  endsequence

  sequence s_count_tick;
    state == DTS_COUNT && tick && quiet;
  endsequence

  sequence s_reset_held;
    (!rst_n_s && enabled && !fault_s && !fault_fall && !INVERT_IN)[*2];
  endsequence

  property p_fall_starts;
    s_fall_taken |=> state == DTS_COUNT && accum == `DTS_ACC_ZERO;
  endproperty
  a_fall_starts: assert property (p_fall_starts)
    else $error("Trigger fall did not start counting from zero");

  property p_rise_clears;
    trig_rise && rst_n_s && !fault_s && !fault_fall
      |=> state == DTS_IDLE && accum == `DTS_ACC_ZERO;
  endproperty
  a_rise_clears: assert property (p_rise_clears)
    else $error("Trigger rise did not clear the accumulator");

  property p_count_step;
    s_count_tick |=> accum == $past(accum) + `DTS_ACC_ONE;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("Accumulator did not advance by one on a tick");

  property p_no_tick_stable;
    state == DTS_COUNT && !tick && quiet |=> $stable(accum);
  endproperty
  a_no_tick_stable: assert property (p_no_tick_stable)
    else $error("Accumulator moved without a tick");

  property p_reach_limit;
    s_count_tick ##0 (accum_inc == eff_limit) |=> state == DTS_HOLD;
  endproperty
  a_reach_limit: assert property (p_reach_limit)
    else $error("Counting did not stop at the limit");

  property p_below_limit;
    state == DTS_COUNT |-> accum < eff_limit;
  endproperty
  a_below_limit: assert property (p_below_limit)
    else $error("Accumulator passed the limit while counting");

  property p_hold_keeps;
    state == DTS_HOLD && quiet |=> state == DTS_HOLD && $stable(accum);
  endproperty
  a_hold_keeps: assert property (p_hold_keeps)
    else $error("Held limit was lost with trigger low");

  property p_early_rise;
    state == DTS_COUNT && trig_rise && rst_n_s && !fault_s && !fault_fall
      |=> state == DTS_IDLE ##1 state != DTS_HOLD;
  endproperty
  a_early_rise: assert property (p_early_rise)
    else $error("Early trigger rise still reached the limit");

  property p_out_level;
    enabled && !fault_s
      |=> OUTPUT_OUT == ($past(at_limit) ~^ $past(INVERT_IN));
  endproperty
  a_out_level: assert property (p_out_level)
    else $error("Output level does not match the limit state");

  property p_out_frozen;
    !enabled || fault_s |=> $stable(OUTPUT_OUT);
  endproperty
  a_out_frozen: assert property (p_out_frozen)
    else $error("Output changed while disabled or in fault");

  property p_reenable;
    !enabled ##1 enabled && !fault_s
      |=> OUTPUT_OUT == (!$past(at_limit) ^ $past(INVERT_IN));
  endproperty
  a_reenable: assert property (p_reenable)
    else $error("Output did not follow state on re-enable");

  property p_disabled_runs;
    s_count_tick and !enabled |=> accum == $past(accum_inc);
  endproperty
  a_disabled_runs: assert property (p_disabled_runs)
    else $error("Timing stopped while disabled");

  property p_reset_zero;
    !rst_n_s && !fault_s && !fault_fall
      |=> accum == `DTS_ACC_ZERO && state == DTS_IDLE;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("Timer reset did not force the accumulator to zero");

  property p_reset_out;
    s_reset_held |=> OUTPUT_OUT;
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("Output not on while timer reset is low");

  property p_fault_recover;
    fault_fall
      |=> state == DTS_HOLD && accum == $past(eff_limit);
  endproperty
  a_fault_recover: assert property (p_fault_recover)
    else $error("Fault clear did not load the limit");

  property p_power_up;
    disable iff (1'b0)
    SYS_RST_IN |=> state == DTS_HOLD;
  endproperty
  a_power_up: assert property (p_power_up)
    else $error("Power-up did not leave the timer at its limit");

  property p_limit_floor;
    COUNT_LIMIT_IN == `DTS_ACC_ZERO |-> eff_limit == `DTS_LIMIT_MIN;
  endproperty
  a_limit_floor: assert property (p_limit_floor)
    else $error("Limit of zero was not raised to one");

  property p_inv_level;
    enabled && !fault_s && INVERT_IN && at_limit |=> OUTPUT_OUT;
  endproperty
  a_inv_level: assert property (p_inv_level)
    else $error("Inverted output not high at the limit");

  property p_never_frozen;
    ENABLE_MODE_IN == DTS_EN_NEVER |=> $stable(OUTPUT_OUT);
  endproperty
  a_never_frozen: assert property (p_never_frozen)
    else $error("Output moved while forced disabled");

  property p_always_follows;
    ENABLE_MODE_IN == DTS_EN_ALWAYS && !fault_s
      |=> OUTPUT_OUT == ($past(at_limit) ~^ $past(INVERT_IN));
  endproperty
  a_always_follows: assert property (p_always_follows)
    else $error("Output not updated while forced enabled");

  property p_fault_freeze;
    fault_s |=> $stable(state) && $stable(accum);
  endproperty
  a_fault_freeze: assert property (p_fault_freeze)
    else $error("Timer state moved during a fault");
endmodule : dts_timer

// ### dts_consts.svh
// Constants for the delay-to-stop timer
`ifndef DTS_CONSTS_SVH
`define DTS_CONSTS_SVH

// Widths
`define DTS_LIMIT_W 15
`define DTS_UNIT_MS_W 14
`define DTS_CYC_W 18
`define DTS_SYNC_W 4

// Clock and millisecond timing
`define DTS_CLK_PERIOD_NS 4
`define DTS_MS_NS 1000000
`define DTS_CYCLES_PER_MS ((`DTS_MS_NS + `DTS_CLK_PERIOD_NS - 1) / `DTS_CLK_PERIOD_NS)

// Milliseconds per time unit
`define DTS_MS_1 14'h0001
`define DTS_MS_10 14'h000A
`define DTS_MS_100 14'h0064
`define DTS_MS_1000 14'h03E8
`define DTS_MS_10000 14'h2710
`define DTS_MS_ONE 14'h0001

// Accumulator and cycle-counter values
`define DTS_ACC_ZERO 15'h0000
`define DTS_ACC_ONE 15'h0001
`define DTS_LIMIT_MIN 15'h0001
`define DTS_CYC_ZERO 18'h00000
`define DTS_CYC_ONE 18'h00001

// Synchroniser lanes
`define DTS_LANE_TRIG 0
`define DTS_LANE_EN 1
`define DTS_LANE_RSTN 2
`define DTS_LANE_FAULT 3
`define DTS_SYNC_IDLE 4'h4

`endif

// ### dts_pkg.sv
// Types for the delay-to-stop timer
package dts_pkg;
  typedef enum logic [2:0] {
    DTS_UNIT_1MS = 3'h0,
    DTS_UNIT_10MS = 3'h1,
    DTS_UNIT_100MS = 3'h2,
    DTS_UNIT_1000MS = 3'h3,
    DTS_UNIT_10000MS = 3'h4
  } dts_unit_t;

  typedef enum logic [1:0] {
    DTS_EN_FOLLOW = 2'h0,
    DTS_EN_ALWAYS = 2'h1,
    DTS_EN_NEVER = 2'h2
  } dts_en_mode_t;

  typedef enum logic [2:0] {
    DTS_IDLE = 3'h1,
    DTS_COUNT = 3'h2,
    DTS_HOLD = 3'h4
  } dts_state_t;
endpackage : dts_pkg

// ### dts_prescaler.sv
// Time-unit tick generator for the delay-to-stop timer
`timescale 1ns/1ps
`include "dts_consts.svh"
module dts_prescaler #(
  parameter int CYCLES_PER_MS = `DTS_CYCLES_PER_MS
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic restart_in,
  input wire logic run_in,
  input wire logic [`DTS_UNIT_MS_W-1:0] ms_per_unit_in,
  output logic tick_out
);
  localparam logic [`DTS_CYC_W-1:0] CYC_LAST =
    `DTS_CYC_W'(CYCLES_PER_MS - 1);

  logic [`DTS_CYC_W-1:0] cyc_cnt;
  logic [`DTS_UNIT_MS_W-1:0] ms_cnt;
  logic ms_tick;
  logic unit_last;
  logic [`DTS_UNIT_MS_W-1:0] ms_last;

  assign ms_last = ms_per_unit_in - `DTS_MS_ONE;
  assign ms_tick = (cyc_cnt == CYC_LAST);
  assign unit_last = (ms_cnt >= ms_last);

  // Cycle and millisecond counters, restarted at each timing start
  always_ff @(posedge clk_in) begin
    if (rst_in || restart_in || !run_in) begin
      cyc_cnt <= `DTS_CYC_ZERO;
      ms_cnt <= '0;
      tick_out <= 1'b0;
    end else begin
      cyc_cnt <= ms_tick ? `DTS_CYC_ZERO : cyc_cnt + `DTS_CYC_ONE;
      tick_out <= ms_tick && unit_last;
      if (ms_tick) begin
        ms_cnt <= unit_last ? '0 : ms_cnt + `DTS_MS_ONE;
      end
    end
  end
endmodule : dts_prescaler

// ### dts_src.sv
// Input source model for the delay-to-stop timer
`timescale 1ns/1ps
module dts_src (
  input wire logic clk_in,
  input wire logic stall_in,
  input wire logic [3:0] lvl_in,
  output logic trig_out,
  output logic en_out,
  output logic rst_n_out,
  output logic fault_out
);
  // Levels move at the falling edge; a stall keeps the old levels
  initial {fault_out, rst_n_out, en_out, trig_out} = 4'h6;
  always @(negedge clk_in) begin
    if (!stall_in) begin
      {fault_out, rst_n_out, en_out, trig_out} <= lvl_in;
    end
  end
endmodule : dts_src

// ### delay_to_stop_timer_test.sv
// Self-checking bench for the delay-to-stop timer
`timescale 1ns/1ps
`include "dts_consts.svh"
module delay_to_stop_timer_test;
  import dts_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic stall = 1'b0;
  logic inv = 1'b0;
  logic [3:0] lvl = 4'h6;
  logic trig, en, rst_n, fault, out, at_lim, cnt_on;
  dts_en_mode_t mode = DTS_EN_FOLLOW;
  dts_unit_t unit = DTS_UNIT_1MS;
  logic [`DTS_LIMIT_W-1:0] lim = 15'h0003;
  logic [`DTS_LIMIT_W-1:0] acc;
  int error_cnt = 0;
  int check_count = 0;

  initial begin
    forever #2 clk = ~clk;
  end

  dts_src src (.clk_in(clk), .stall_in(stall), .lvl_in(lvl),
    .trig_out(trig), .en_out(en), .rst_n_out(rst_n), .fault_out(fault));
  dts_timer #(.CYCLES_PER_MS(4)) dut (.CLK_IN(clk), .SYS_RST_IN(rst),
    .TRIGGER_IN(trig), .ENABLE_IN(en), .TIMER_RST_N_IN(rst_n),
    .FAULT_IN(fault), .ENABLE_MODE_IN(mode), .UNIT_SEL_IN(unit),
    .COUNT_LIMIT_IN(lim), .INVERT_IN(inv), .OUTPUT_OUT(out),
    .ACCUM_OUT(acc), .AT_LIMIT_OUT(at_lim), .COUNTING_OUT(cnt_on));

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %0h, expected %0h", $time, seen, exp);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task pin(input int i, input logic v, input int n);
    lvl[i] <= v;
    cyc(n);
  endtask : pin

  task wait_lim(input int bound, output int n);
    n = 0;
    while (at_lim !== 1'b1 && n < bound) begin
      cyc(1);
      n++;
    end
  endtask : wait_lim

  task run(input dts_unit_t u, input int ms, input int c);
    int n;
    int t;
    unit <= u;
    lim <= c[14:0];
    pin(0, 1'b1, 8);
    chk(acc, 0);
    chk(out, !inv);
    pin(0, 1'b0, 6);
    chk(cnt_on, 1);
    chk(acc, 0);
    t = 4 * ms * c;
    wait_lim(t + c + 20, n);
    chk(n + 6 >= t, 1);
    chk(n + 6 <= t + c + 10, 1);
    chk(acc, 16'(c));
    cyc(20);
    chk(acc, 16'(c));
    chk(cnt_on, 0);
    chk(out, inv);
  endtask : run

  task early();
    logic bad;
    bad = 1'b0;
    unit <= DTS_UNIT_1MS;
    lim <= 15'h7FFF;
    pin(0, 1'b1, 8);
    pin(0, 1'b0, 20);
    chk(acc != 0, 1);
    lvl[0] <= 1'b1;
    repeat (30) begin
      cyc(1);
      bad |= (out !== 1'b1);
    end
    chk(bad, 0);
    chk(acc, 0);
  endtask : early

  task enable();
    int n;
    lim <= 15'h0002;
    pin(0, 1'b1, 8);
    pin(1, 1'b0, 6);
    pin(0, 1'b0, 1);
    wait_lim(40, n);
    chk(at_lim, 1);
    cyc(4);
    chk(out, 1);
    pin(1, 1'b1, 6);
    chk(out, 0);
    mode <= DTS_EN_NEVER;
    pin(0, 1'b1, 8);
    chk(acc, 0);
    chk(out, 0);
    mode <= DTS_EN_ALWAYS;
    pin(1, 1'b0, 3);
    chk(out, 1);
    mode <= DTS_EN_FOLLOW;
    pin(1, 1'b1, 2);
  endtask : enable

  task treset();
    int n;
    lim <= 15'h0005;
    pin(0, 1'b1, 8);
    pin(0, 1'b0, 10);
    stall <= 1'b1;
    pin(2, 1'b0, 6);
    chk(cnt_on, 1);
    stall <= 1'b0;
    cyc(6);
    chk(acc, 0);
    chk(cnt_on, 0);
    cyc(30);
    chk(at_lim, 0);
    chk(out, 1);
    pin(2, 1'b1, 4);
    pin(0, 1'b1, 8);
    pin(0, 1'b0, 1);
    wait_lim(60, n);
    chk(at_lim, 1);
    cyc(20);
    chk(out, 0);
  endtask : treset

  task fault_case();
    pin(3, 1'b1, 6);
    pin(0, 1'b1, 10);
    chk(out, 0);
    lim <= 15'h0004;
    pin(0, 1'b0, 6);
    pin(3, 1'b0, 6);
    chk(at_lim, 1);
    chk(acc, 4);
    chk(out, 0);
  endtask : fault_case

  task zero_lim();
    int n;
    unit <= dts_unit_t'(3'h5);
    lim <= 15'h0000;
    pin(0, 1'b1, 8);
    pin(0, 1'b0, 1);
    wait_lim(30, n);
    chk(at_lim, 1);
    chk(acc, 1);
    chk(n < 12, 1);
  endtask : zero_lim

  task end_sim();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  // Longest run is about 40000 cycles
  initial begin
    #360000;
    error_cnt++;
    end_sim();
  end

  initial begin
    cyc(2);
    rst <= 1'b0;
    cyc(1);
    chk(at_lim, 1);
    chk(acc, 3);
    chk(out, 0);
    run(DTS_UNIT_1MS, 1, 1);
    run(DTS_UNIT_10MS, 10, 1);
    run(DTS_UNIT_100MS, 100, 1);
    run(DTS_UNIT_1000MS, 1000, 1);
    run(DTS_UNIT_10000MS, 10000, 1);
    run(DTS_UNIT_1MS, 1, 3);
    inv <= 1'b1;
    run(DTS_UNIT_10MS, 10, 2);
    inv <= 1'b0;
    early();
    enable();
    treset();
    fault_case();
    zero_lim();
    end_sim();
  end
endmodule : delay_to_stop_timer_test
